// ==== hw/dicd_pkg.sv ====
// Package for the signal-processor interrupt control and converter data block.
// Assumes one clock shared by processor and host core.
package dicd_pkg;

  // ********************************
  // Register port select
  // ********************************
  localparam logic PORT_ICR = 1'h0;
  localparam logic PORT_CDR = 1'h1;

  // ********************************
  // Control register fields
  // ********************************
  localparam int BIT_HOST_FLAG = 15;
  localparam int BIT_CONV_FLAG = 14;
  localparam int BIT_OUT_FLAG = 13;
  localparam int BIT_MASK_HI = 12;
  localparam int BIT_MASK_MID = 11;
  localparam int BIT_MASK_LO = 10;
  localparam int BIT_DOORBELL = 9;
  localparam int BIT_GIE = 8;
  localparam int BIT_ROUTE_LSB = 5;
  localparam int BIT_CLR_HOST = 4;
  localparam int BIT_CLR_CONV = 3;
  localparam int BIT_CLR_OUT = 2;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic GIE_RESET = 1'h0;

  // ********************************
  // Converter data fields
  // ********************************
  localparam int DAC_WIDTH = 10;
  localparam int ADC_WIDTH = 8;
  localparam int ADC_LSB = 2;

  // ********************************
  // Doorbell acknowledge delay
  // ********************************
  localparam logic [1:0] ACK_HOST_INSTR = 2'h3;

  // Line index: 2 high, 1 middle, 0 low
  typedef enum logic [1:0] {DICD_LINE_LO, DICD_LINE_MID, DICD_LINE_HI, DICD_LINE_NONE} dicd_line_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [15:0] wdata;
  } dicd_req_s;

  typedef struct packed {
    logic host_set;
    logic host_ack;
    logic host_instr;
    logic conv_done;
    logic rate_tick;
  } dicd_evt_s;

endpackage

// ==== hw/dicd_core.sv ====
// Interrupt control unit and converter data register of the signal processor.
// Assumes processor and host core share clk; all inputs are synchronous to it.
//
// Contract
// - Three lines, high over middle over low.
// - No new interrupt while a routine runs.
// - Simultaneous requests: highest priority taken first.
// - Bit 15 host flag, set by host only.
// - Bit 14 set on valid conversion data.
// - Bit 13 set by output-rate timer.
// - Bits 12..10 line masks, 1 allows.
// - Bit 9 write drives host doorbell, reads 0.
// - Doorbell cleared three host instructions after acknowledge.
// - Bit 8 global enable, cleared by reset.
// - Route codes 000, 001, 010 as tabled.
// - Route codes 011, 100, 101; 110/111 reserved.
// - Bits 4..2 write-one clear strobes, read 0.
// - Data write loads 10-bit output value.
// - Data read gives 8-bit result in 9..2.
// - Timer final count sets output-rate flag.
`timescale 1ns/1ns
module dicd_core
  import dicd_pkg::*;
#(
  parameter int DAC_W = dicd_pkg::DAC_WIDTH,
  parameter int ADC_W = dicd_pkg::ADC_WIDTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire dicd_pkg::dicd_req_s req,
  input wire dicd_pkg::dicd_evt_s evt,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic isr_done,
  output logic [15:0] rdata,
  output logic [2:0] line_req,
  output logic [1:0] line_vec,
  output logic irq_take,
  output logic isr_busy,
  output logic host_doorbell,
  output logic host_request_flag_out,
  output logic [DAC_W-1:0] dac_data
);
  import dicd_pkg::*;

  // ********************************
  // State
  // ********************************
  logic [2:0] flags_r, flags_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic gie_r, gie_nxt;
  logic [2:0] route_r, route_nxt;
  logic bell_r, bell_nxt;
  logic ack_pend_r, ack_pend_nxt;
  logic [1:0] ack_cnt_r, ack_cnt_nxt;
  logic busy_r, busy_nxt;
  logic take_r, take_nxt;
  dicd_line_e vec_r, vec_nxt;
  logic [2:0] lines_r, lines_nxt;
  logic [DAC_W-1:0] dac_r, dac_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  logic wr_icr, wr_cdr, rd_icr, rd_cdr;
  logic [2:0] set_src, clr_src;
  logic [2:0] routed;
  dicd_line_e pick;

  assign wr_icr = req.wr && req.sel == PORT_ICR;
  assign wr_cdr = req.wr && req.sel == PORT_CDR;
  assign rd_icr = req.rd && req.sel == PORT_ICR;
  assign rd_cdr = req.rd && req.sel == PORT_CDR;

  // ********************************
  // Source flags: index 2 host, 1 conversion, 0 output
  // ********************************
  always_comb begin
    set_src[2] = evt.host_set;
    set_src[1] = evt.conv_done;
    set_src[0] = evt.rate_tick;
    clr_src = wr_icr ? {req.wdata[BIT_CLR_HOST], req.wdata[BIT_CLR_CONV], req.wdata[BIT_CLR_OUT]} : 3'h0;
  end

  // Set wins over clear so no event is lost
  for (genvar g = 0; g < 3; g++) begin : g_flag
    assign flags_nxt[g] = (flags_r[g] && !clr_src[g]) || set_src[g];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 3'h0;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      flags_r <= flags_nxt;
    end
  end

  // ********************************
  // Control fields
  // ********************************
  always_comb begin
    mask_nxt = mask_r;
    gie_nxt = gie_r;
    route_nxt = route_r;
    if (wr_icr) begin
      mask_nxt = {req.wdata[BIT_MASK_HI], req.wdata[BIT_MASK_MID], req.wdata[BIT_MASK_LO]};
      gie_nxt = req.wdata[BIT_GIE];
      route_nxt = req.wdata[BIT_ROUTE_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= MASK_RESET;
      gie_r <= GIE_RESET;
      route_r <= ROUTE_RESET;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      mask_r <= mask_nxt;
      gie_r <= gie_nxt;
      route_r <= route_nxt;
    end
  end

  // ********************************
  // Doorbell toward host
  // ********************************
  always_comb begin
    bell_nxt = bell_r;
    ack_pend_nxt = ack_pend_r;
    ack_cnt_nxt = ack_cnt_r;
    if (ack_pend_r && evt.host_instr) begin
      if (ack_cnt_r == ACK_HOST_INSTR - 2'h1) begin
        bell_nxt = 1'b0;
        ack_pend_nxt = 1'b0;
        ack_cnt_nxt = 2'h0;
      end else begin
        ack_cnt_nxt = ack_cnt_r + 2'h1;
      end
    end
    if (evt.host_ack && bell_r) begin
      ack_pend_nxt = 1'b1;
      ack_cnt_nxt = 2'h0;
    end
    if (wr_icr) begin
      bell_nxt = req.wdata[BIT_DOORBELL];
      if (req.wdata[BIT_DOORBELL]) begin
        ack_pend_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bell_r <= 1'b0;
      ack_pend_r <= 1'b0;
      ack_cnt_r <= 2'h0;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      bell_r <= bell_nxt;
      ack_pend_r <= ack_pend_nxt;
      ack_cnt_r <= ack_cnt_nxt;
    end
  end

  // ********************************
  // Routing and priority
  // ********************************
  always_comb begin
    routed = 3'h0;
    // codes 000 to 101, rest none
    case (route_r)
      3'h0: routed = {flags_r[2], flags_r[1], flags_r[0]};
      3'h1: routed = {flags_r[1], flags_r[2], flags_r[0]};
      3'h2: routed = {flags_r[2], flags_r[0], flags_r[1]};
      3'h3: routed = {flags_r[0], flags_r[2], flags_r[1]};
      3'h4: routed = {flags_r[1], flags_r[0], flags_r[2]};
      3'h5: routed = {flags_r[0], flags_r[1], flags_r[2]};
      default: routed = 3'h0;
    endcase
    lines_nxt = gie_r ? (routed & mask_r) : 3'h0;
    if (lines_r[2]) begin
      pick = DICD_LINE_HI;
    end else if (lines_r[1]) begin
      pick = DICD_LINE_MID;
    end else if (lines_r[0]) begin
      pick = DICD_LINE_LO;
    end else begin
      pick = DICD_LINE_NONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lines_r <= 3'h0;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      lines_r <= lines_nxt;
    end
  end

  // ********************************
  // Service tracking
  // ********************************
  always_comb begin
    busy_nxt = busy_r;
    take_nxt = 1'b0;
    vec_nxt = vec_r;
    if (busy_r) begin
      if (isr_done) begin
        busy_nxt = 1'b0;
      end
    end else if (pick != DICD_LINE_NONE && lines_nxt != 3'h0) begin
      busy_nxt = 1'b1;
      take_nxt = 1'b1;
      vec_nxt = pick;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      take_r <= 1'b0;
      vec_r <= DICD_LINE_NONE;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      busy_r <= busy_nxt;
      take_r <= take_nxt;
      vec_r <= vec_nxt;
    end
  end

  // ********************************
  // Converter data and read mux
  // ********************************
  always_comb begin
    dac_nxt = wr_cdr ? req.wdata[DAC_W-1:0] : dac_r;
    rdata_nxt = rdata_r;
    if (rd_icr) begin
      // virtual and reserved bits read 0
      rdata_nxt = {flags_r, mask_r, 1'b0, gie_r, route_r, 5'h00};
    end else if (rd_cdr) begin
      rdata_nxt = 16'h0000;
      rdata_nxt[ADC_LSB +: ADC_W] = adc_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_r <= '0;
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      // Frozen while clk_en is low
      dac_r <= dac_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign rdata = rdata_r;
  assign line_req = lines_r;
  assign line_vec = vec_r;
  assign irq_take = take_r;
  assign isr_busy = busy_r;
  assign host_doorbell = bell_r;
  assign host_request_flag_out = flags_r[2];
  assign dac_data = dac_r;

endmodule

// ==== verification/dicd_host_model.sv ====
// Host core stand-in: request writes, doorbell acknowledge, instruction stream.
// Assumes the host shares the processor clock.
`timescale 1ns/1ns
module dicd_host_model #(
  parameter int LAG = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic kick,
  input wire logic bell,
  output logic host_set,
  output logic host_ack,
  output logic host_instr
);
  int cnt;
  assign host_set = kick;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      host_ack <= 1'b0;
      host_instr <= 1'b0;
    end else begin
      cnt <= bell ? cnt + 1 : 0;
      host_ack <= bell && cnt == LAG;
      // Every other cycle, so the count is not trivially back to back
      host_instr <= !host_instr;
    end
  end
endmodule

// ==== verification/dicd_core_properties.sv ====
// Checker for the interrupt control block, bound to dicd_core.
// Assumes one clock domain and clk_en held high.
`timescale 1ns/1ns
module dicd_core_properties
  import dicd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire dicd_pkg::dicd_req_s req,
  input wire logic isr_done,
  input wire logic [2:0] line_req,
  input wire logic [1:0] line_vec,
  input wire logic irq_take,
  input wire logic isr_busy,
  input wire logic host_doorbell
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_bell_on;
    clk_en && req.wr && req.sel == PORT_ICR && req.wdata[9];
  endsequence
  sequence s_bell_off;
    clk_en && req.wr && req.sel == PORT_ICR && !req.wdata[9];
  endsequence
  a_take_idle: assert property (irq_take |-> !$past(isr_busy))
    else $error("take while busy");
  a_take_once: assert property (irq_take && !isr_done |=> isr_busy && !irq_take)
    else $error("take not held busy");
  a_take_line: assert property (irq_take |-> $past(line_req) != 3'h0)
    else $error("take without line");
  a_prio_high: assert property (irq_take && $past(line_req[2]) |-> line_vec == DICD_LINE_HI)
    else $error("high line not first");
  a_prio_mid: assert property (irq_take && $past(line_req[2:1]) == 2'h1 |-> line_vec == DICD_LINE_MID)
    else $error("middle line not first");
  a_busy_hold: assert property (isr_busy && !isr_done && clk_en |=> isr_busy)
    else $error("routine ended early");
  a_bell_set: assert property (s_bell_on |=> host_doorbell)
    else $error("doorbell not raised");
  a_bell_drop: assert property (s_bell_off |=> !host_doorbell)
    else $error("doorbell not dropped");
endmodule
bind dicd_core dicd_core_properties chk_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req(req),
  .isr_done(isr_done), .line_req(line_req), .line_vec(line_vec), .irq_take(irq_take), .isr_busy(isr_busy),
  .host_doorbell(host_doorbell));

// ==== verification/tb.sv ====
// Self-checking bench for the interrupt control and converter data block.
// Assumes dicd_host_model stands in for the host core.
`timescale 1ns/1ns
module tb;
  import dicd_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic isr_done = 1'b0;
  logic ce = 1'b1;
  logic [2:0] ev = 3'h0;
  logic [7:0] adc = 8'hA5;
  dicd_req_s req = '0;
  dicd_evt_s evt;
  logic hs, ha, hi, irq_take, isr_busy, bell, hflag;
  logic [15:0] rdata;
  logic [2:0] line_req;
  logic [1:0] line_vec;
  logic [9:0] dac;
  logic [5:0] rt [6] = '{6'h24, 6'h18, 6'h21, 6'h12, 6'h09, 6'h06};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  assign evt = {hs, ha, hi, ev[1], ev[0]};
  always #25 clk = ~clk;
  dicd_host_model #(.LAG(3)) host_u (.clk(clk), .arst_n(arst_n), .kick(ev[2]), .bell(bell), .host_set(hs),
    .host_ack(ha), .host_instr(hi));
  dicd_core dut_u (.clk(clk), .arst_n(arst_n), .clk_en(ce), .req(req), .evt(evt), .adc_data(adc),
    .isr_done(isr_done), .rdata(rdata), .line_req(line_req), .line_vec(line_vec), .irq_take(irq_take),
    .isr_busy(isr_busy), .host_doorbell(bell), .host_request_flag_out(hflag), .dac_data(dac));
  task automatic close_out();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [15:0] d);
    req <= '{wr: w, rd: !w, sel: s, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  // Pulse sources, then wait a bounded time for the take
  task automatic fire(input logic [2:0] e, input logic [1:0] x);
    int i;
    ev <= e;
    @(posedge clk);
    ev <= 3'h0;
    for (i = 0; i < 12 && irq_take !== 1'b1; i++) @(posedge clk);
    chk({14'h0, irq_take === 1'b1 ? line_vec : 2'h3}, {14'h0, x});
  endtask
  task automatic svc(input logic [15:0] d);
    acc(1'b1, PORT_ICR, d);
    isr_done <= 1'b1;
    @(posedge clk);
    isr_done <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    acc(1'b0, PORT_ICR, 16'h0000);
    chk(rdata, 16'h0000);
    acc(1'b1, PORT_ICR, 16'hFFFF);
    chk({15'h0, bell}, 16'h0001);
    repeat (20) @(posedge clk);
    chk({15'h0, bell}, 16'h0000);
    acc(1'b0, PORT_ICR, 16'h0000);
    chk(rdata, 16'h1DE0);
    acc(1'b1, PORT_ICR, 16'h0100);
    fire(3'h2, 2'h3);
    acc(1'b1, PORT_ICR, 16'h1C00);
    fire(3'h2, 2'h3);
    acc(1'b1, PORT_ICR, 16'h1D00);
    fire(3'h0, 2'h1);
    svc(16'h1D1C);
    fire(3'h7, 2'h2);
    chk({15'h0, hflag}, 16'h0001);
    svc(16'h1D10);
    fire(3'h0, 2'h1);
    svc(16'h1D08);
    fire(3'h0, 2'h0);
    svc(16'h1D1C);
    for (int c = 0; c < 6; c++) begin
      for (int s = 0; s < 3; s++) begin
        acc(1'b1, PORT_ICR, 16'h1D00 | 16'(c * 32));
        fire(3'(1 << s), rt[c][2*s +: 2]);
        svc(16'h1D1C | 16'(c * 32));
      end
    end
    acc(1'b1, PORT_CDR, 16'hFFFF);
    chk({6'h0, dac}, 16'h03FF);
    ce <= 1'b0;
    acc(1'b1, PORT_CDR, 16'h0000);
    ce <= 1'b1;
    chk({6'h0, dac}, 16'h03FF);
    acc(1'b0, PORT_CDR, 16'h0000);
    chk(rdata, 16'h0294);
    close_out();
  end
endmodule
